// ==== include/logic_eval_pkg.sv ====
// constants, entry encoding and state type for the postfix logic evaluator
// assumes a 200 MHz core clock and a 60 Hz power system
package logic_eval_pkg;

  // entry layout: opcode in the upper bits, index or input count below
  localparam int ENTRY_W = 13;
  localparam int OP_MSB = 12;
  localparam int OP_LSB = 8;
  localparam int ARG_MSB = 7;
  localparam int ARG_LSB = 0;

  // opcodes
  localparam logic [4:0] OP_END = 5'h00;
  localparam logic [4:0] OP_CONTACT = 5'h01;
  localparam logic [4:0] OP_PICKUP = 5'h02;
  localparam logic [4:0] OP_OPERATED = 5'h03;
  localparam logic [4:0] OP_REMOTE = 5'h04;
  localparam logic [4:0] OP_STORED = 5'h05;
  localparam logic [4:0] OP_TIMER_OUT = 5'h06;
  localparam logic [4:0] OP_ON = 5'h07;
  localparam logic [4:0] OP_OFF = 5'h08;
  localparam logic [4:0] OP_NOT = 5'h09;
  localparam logic [4:0] OP_OR = 5'h0A;
  localparam logic [4:0] OP_AND = 5'h0B;
  localparam logic [4:0] OP_NOR = 5'h0C;
  localparam logic [4:0] OP_NAND = 5'h0D;
  localparam logic [4:0] OP_XOR = 5'h0E;
  localparam logic [4:0] OP_LATCH = 5'h0F;
  localparam logic [4:0] OP_TIMER = 5'h10;
  localparam logic [4:0] OP_ASSIGN = 5'h11;

  // resource counts
  localparam int NUM_STORED = 64;
  localparam int NUM_TIMERS = 32;
  localparam int NUM_LATCHES = 16;
  localparam int NUM_CONTACTS = 32;
  localparam int NUM_ELEMENTS = 16;
  localparam int NUM_REMOTE = 32;
  localparam int EQ_DEPTH_DEF = 512;
  localparam int STACK_DEPTH_DEF = 16;
  localparam int GATE_MIN_INPUTS = 2;
  localparam int GATE_MAX_INPUTS = 16;
  localparam int DELAY_W = 16;

  // operand counts of the fixed-arity operators
  localparam logic [7:0] NEED_NONE = 8'h00;
  localparam logic [7:0] NEED_ONE = 8'h01;
  localparam logic [7:0] NEED_TWO = 8'h02;

  // scan timing: passes per power cycle, longest period rounds down
  localparam longint CLK_HZ = 200_000_000;
  localparam longint POWER_FREQ_HZ = 60;
  localparam longint PASSES_PER_CYCLE = 4;
  localparam int SCAN_PERIOD_CYCLES = int'(CLK_HZ / (POWER_FREQ_HZ * PASSES_PER_CYCLE));

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} run_state_t;

endpackage

// ==== core/eval_timer_bank.sv ====
// bank of pickup/dropout delay timers driven by the evaluator
// delays come from settings held outside, counted in core clocks
`timescale 1ns/1ps
`default_nettype none

module eval_timer_bank #(
  parameter int NUM = 32,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic clear_in,
  // timer inputs and delay settings
  input wire logic [NUM-1:0] start_in,
  input wire logic [NUM*DW-1:0] pickup_delay_in,
  input wire logic [NUM*DW-1:0] dropout_delay_in,
  // timer outputs
  output logic [NUM-1:0] timer_out
);

  initial
  begin
    if (NUM < 1 || DW < 1)
      $error("timer bank needs at least one timer and one delay bit");
  end

  genvar i;
  generate
    for (i = 0; i < NUM; i++)
    begin : g_tmr
      typedef struct packed {
        logic out;
        logic [DW-1:0] cnt;
      } tmr_state_t;
      tmr_state_t r;
      tmr_state_t next_r;
      logic [DW-1:0] delay;

      always_comb
      begin
        next_r = r;
        delay = start_in[i] ? pickup_delay_in[i*DW +: DW] : dropout_delay_in[i*DW +: DW];
        if (start_in[i] == r.out)
          next_r.cnt = '0;
        else if (r.cnt >= delay)
        begin
          // zero delay follows the input on the next edge
          next_r.out = start_in[i];
          next_r.cnt = '0;
        end
        else
          next_r.cnt = r.cnt + 1'b1;
        if (clear_in)
          next_r = '0;
      end

      always_ff @(posedge core_clk_in)
      begin
        if (rst_in)
          r <= '0;
        else
          r <= next_r;
      end

      assign timer_out[i] = r.out;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== core/logic_eval.sv ====
// postfix logic equation evaluator: scans the stored entry list and updates
// the stored result bits; operand flags come from logic on the same clock,
// field contacts come from pins and are synchronised here
//
// Contract
// RULE1: entries are evaluated one per cycle in stored order.
// RULE2: latch output stays set after set until reset clears it, across passes.
// RULE3: reset at power-up clears every latch.
// RULE4: any settings write clears latches and restarts evaluation.
// RULE5: source assigns each of 64 stored result bits at most once.
// RULE6: gates take 2 to 16 inputs; wider functions are split by the source.
// RULE7: a result used twice is stored first and then referenced.
// RULE8: a gate of count N combines the N newest results, leaving one.
// RULE9: inversion complements the single newest result.
// RULE10: a timer is started by the newest result; its output is pushed.
// RULE11: each contact reads true when closed or open, chosen per input.
// RULE12: full passes run at least 4 times per power cycle.
// RULE13: a stored bit read before its assignment gives last pass's value.
// RULE14: latch reset is the newest result, set the one before; reset wins.
// RULE15: a pass stops at the first end entry.
// RULE16: a repeated timer or stored-bit assignment flags a syntax error.
// RULE17: periodic strobe starts a pass on an operand stack; done pulses at end.
// RULE18: too few stacked inputs raise an error and force the result false.
`timescale 1ns/1ps
`default_nettype none

module logic_eval #(
  parameter int EQ_DEPTH = logic_eval_pkg::EQ_DEPTH_DEF,
  parameter int STACK_DEPTH = logic_eval_pkg::STACK_DEPTH_DEF,
  parameter int SCAN_PERIOD = logic_eval_pkg::SCAN_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // settings write port
  input wire logic cfg_wr_in,
  input wire logic [$clog2(EQ_DEPTH)-1:0] cfg_addr_in,
  input wire logic [logic_eval_pkg::ENTRY_W-1:0] cfg_data_in,
  input wire logic [logic_eval_pkg::NUM_CONTACTS-1:0] contact_true_when_open_in,
  input wire logic [logic_eval_pkg::NUM_TIMERS*logic_eval_pkg::DELAY_W-1:0] timer_pickup_delay_in,
  input wire logic [logic_eval_pkg::NUM_TIMERS*logic_eval_pkg::DELAY_W-1:0] timer_dropout_delay_in,
  // operand sources
  input wire logic [logic_eval_pkg::NUM_CONTACTS-1:0] field_contact_input_in,
  input wire logic [logic_eval_pkg::NUM_ELEMENTS-1:0] pickup_flag_in,
  input wire logic [logic_eval_pkg::NUM_ELEMENTS-1:0] operated_flag_in,
  input wire logic [logic_eval_pkg::NUM_REMOTE-1:0] remote_command_bit_in,
  // results and status
  output logic [logic_eval_pkg::NUM_STORED-1:0] stored_result_bit_out,
  output logic pass_done_out,
  output logic syntax_error_out,
  output logic stack_error_out
);
  import logic_eval_pkg::*;

  localparam int AW = $clog2(EQ_DEPTH);
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam logic [AW-1:0] LAST_ADDR = AW'(EQ_DEPTH - 1);
  localparam logic [31:0] SCAN_LAST = 32'(SCAN_PERIOD - 1);
  localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);
  localparam logic [STACK_DEPTH-1:0] STK_ONE = STACK_DEPTH'(1);

  initial
  begin
    if (EQ_DEPTH < 2 || STACK_DEPTH < GATE_MAX_INPUTS || STACK_DEPTH > 255 || SCAN_PERIOD < 1)
      $error("logic_eval: unsupported parameter values");
  end

  typedef struct packed {
    run_state_t st;
    logic [AW-1:0] pc;
    logic pending;
    logic [31:0] scan_cnt;
    logic [STACK_DEPTH-1:0] stk;
    logic [SPW-1:0] sp;
    logic [NUM_STORED-1:0] stored;
    logic [NUM_LATCHES-1:0] latch;
    logic [NUM_TIMERS-1:0] tmr_start;
    logic [NUM_STORED-1:0] seen_assign;
    logic [NUM_TIMERS-1:0] seen_timer;
    logic pass_syntax;
    logic pass_stack;
    logic syntax_err;
    logic stack_err;
    logic done;
    logic timer_clear;
    logic [EQ_DEPTH-1:0] loaded;
    logic [NUM_CONTACTS-1:0] cin_meta;
    logic [NUM_CONTACTS-1:0] cin_sync;
  } state_t;

  state_t r;
  state_t next_r;

  // ---------------------------------------------------------------------------
  // equation store
  // ---------------------------------------------------------------------------
  logic [ENTRY_W-1:0] eq_mem [EQ_DEPTH];

  always_ff @(posedge core_clk_in)
  begin
    if (cfg_wr_in)
      eq_mem[cfg_addr_in] <= cfg_data_in;
  end

  // ---------------------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------------------
  logic [NUM_TIMERS-1:0] tmr_out;

  eval_timer_bank #(
    .NUM(NUM_TIMERS),
    .DW(DELAY_W)
  ) u_timers (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .clear_in(r.timer_clear),
    .start_in(r.tmr_start),
    .pickup_delay_in(timer_pickup_delay_in),
    .dropout_delay_in(timer_dropout_delay_in),
    .timer_out(tmr_out)
  );

  // ---------------------------------------------------------------------------
  // evaluation
  // ---------------------------------------------------------------------------
  logic [ENTRY_W-1:0] entry;
  logic [4:0] op;
  logic [7:0] arg;
  logic [7:0] need;
  logic [7:0] popn;
  logic [SPW-1:0] sp_pop;
  logic [STACK_DEPTH-1:0] stk_pop;
  logic [STACK_DEPTH-1:0] mask;
  logic is_gate;
  logic fault;
  logic res;
  logic push;
  logic finish;
  logic lset;
  logic lrst;

  always_comb
  begin
    next_r = r;
    entry = r.loaded[r.pc] ? eq_mem[r.pc] : {OP_END, 8'h00};
    op = entry[OP_MSB:OP_LSB];
    arg = entry[ARG_MSB:ARG_LSB];
    is_gate = (op == OP_OR) || (op == OP_AND) || (op == OP_NOR) || (op == OP_NAND);
    unique case (op)
      OP_NOT, OP_TIMER, OP_ASSIGN: need = NEED_ONE;
      OP_XOR, OP_LATCH: need = NEED_TWO;
      OP_OR, OP_AND, OP_NOR, OP_NAND: need = arg;
      default: need = NEED_NONE;
    endcase
    // too few stacked inputs or an illegal gate width poisons the result
    fault = (need > 8'(r.sp)) ||
            (is_gate && (arg < 8'(GATE_MIN_INPUTS) || arg > 8'(GATE_MAX_INPUTS))); // [RULE6] [RULE18]
    popn = fault ? 8'(r.sp) : need;
    sp_pop = r.sp - SPW'(popn);
    stk_pop = r.stk >> popn;
    mask = (STK_ONE << need) - STK_ONE;
    lrst = r.stk[0];
    lset = r.stk[1];
    res = 1'b0;
    push = 1'b1;
    finish = (op == OP_END) || (r.pc == LAST_ADDR); // [RULE15]
    next_r.done = 1'b0;
    next_r.timer_clear = 1'b0;
    next_r.cin_meta = field_contact_input_in;
    next_r.cin_sync = r.cin_meta;

    unique case (r.st)
      ST_IDLE:
      begin
        if (r.pending)
        begin
          next_r.pending = 1'b0;
          next_r.st = ST_RUN;
          next_r.pc = '0;
          next_r.sp = '0;
          next_r.stk = '0;
          next_r.seen_assign = '0;
          next_r.seen_timer = '0;
          next_r.pass_syntax = 1'b0;
          next_r.pass_stack = 1'b0;
        end
      end
      ST_RUN:
      begin
        unique case (op)
          OP_CONTACT: res = r.cin_sync[arg[4:0]] ^ contact_true_when_open_in[arg[4:0]]; // [RULE11]
          OP_PICKUP: res = pickup_flag_in[arg[3:0]];
          OP_OPERATED: res = operated_flag_in[arg[3:0]];
          OP_REMOTE: res = remote_command_bit_in[arg[4:0]];
          OP_STORED: res = r.stored[arg[5:0]]; // [RULE13]
          OP_TIMER_OUT: res = tmr_out[arg[4:0]];
          OP_ON: res = 1'b1;
          OP_NOT: res = ~r.stk[0]; // [RULE9]
          OP_OR: res = |(r.stk & mask); // [RULE8]
          OP_AND: res = &(r.stk | ~mask); // [RULE8]
          OP_NOR: res = ~|(r.stk & mask); // [RULE8]
          OP_NAND: res = ~&(r.stk | ~mask); // [RULE8]
          OP_XOR: res = r.stk[0] ^ r.stk[1];
          OP_LATCH:
          begin
            // reset dominant; state survives between passes
            res = ~lrst & (lset | r.latch[arg[3:0]]); // [RULE2] [RULE14]
            if (!fault)
              next_r.latch[arg[3:0]] = res;
          end
          OP_TIMER:
          begin
            // output lags the start by the delay; pushed value is current output
            if (!fault)
              next_r.tmr_start[arg[4:0]] = r.stk[0]; // [RULE10]
            res = tmr_out[arg[4:0]]; // [RULE10]
            if (r.seen_timer[arg[4:0]])
              next_r.pass_syntax = 1'b1; // [RULE16]
            next_r.seen_timer[arg[4:0]] = 1'b1;
          end
          OP_ASSIGN:
          begin
            push = 1'b0;
            if (!fault)
              next_r.stored[arg[5:0]] = r.stk[0];
            if (r.seen_assign[arg[5:0]])
              next_r.pass_syntax = 1'b1; // [RULE16]
            next_r.seen_assign[arg[5:0]] = 1'b1;
          end
          OP_END: push = 1'b0;
          default: res = 1'b0;
        endcase
        if (fault)
        begin
          res = 1'b0; // [RULE18]
          next_r.pass_stack = 1'b1; // [RULE18]
        end
        // pop the consumed operands, then push the single result
        next_r.stk = stk_pop; // [RULE8]
        next_r.sp = sp_pop;
        if (push)
        begin
          next_r.stk = {stk_pop[STACK_DEPTH-2:0], res};
          if (sp_pop == SP_FULL)
            next_r.pass_stack = 1'b1; // oldest entry falls off the bottom
          else
            next_r.sp = sp_pop + 1'b1;
        end
        if (finish)
        begin
          next_r.st = ST_IDLE;
          next_r.done = 1'b1; // [RULE17]
          next_r.syntax_err = next_r.pass_syntax;
          next_r.stack_err = next_r.pass_stack;
        end
        else
          next_r.pc = r.pc + 1'b1; // [RULE1]
      end
    endcase

    // periodic scan strobe; a tick during a pass waits in pending
    if (r.scan_cnt == SCAN_LAST)
    begin
      next_r.scan_cnt = '0;
      next_r.pending = 1'b1; // [RULE12] [RULE17]
    end
    else
      next_r.scan_cnt = r.scan_cnt + 32'h0000_0001;

    // a settings write abandons the pass, clears latches and timers and requests a new one
    if (cfg_wr_in)
    begin
      next_r.loaded[cfg_addr_in] = 1'b1;
      next_r.latch = '0; // [RULE4]
      next_r.tmr_start = '0;
      next_r.timer_clear = 1'b1;
      next_r.st = ST_IDLE;
      next_r.pending = 1'b1; // [RULE4]
      next_r.done = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      r <= '0; // [RULE3]
    else
      r <= next_r;
  end

  assign stored_result_bit_out = r.stored;
  assign pass_done_out = r.done;
  assign syntax_error_out = r.syntax_err;
  assign stack_error_out = r.stack_err;

endmodule

`default_nettype wire

// ==== dv/logic_eval_chk.sv ====
// port checker for the postfix logic evaluator
// bound to logic_eval from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module logic_eval_chk #(
  parameter int EQ_DEPTH = 512,
  parameter int SCAN_PERIOD = 600
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // watched ports
  input wire logic cfg_wr_in,
  input wire logic [logic_eval_pkg::NUM_STORED-1:0] stored_result_bit_out,
  input wire logic pass_done_out,
  input wire logic syntax_error_out,
  input wire logic stack_error_out
);
  import logic_eval_pkg::*;
  // longest quiet spell: one scan period plus a full list
  localparam int LIMIT = SCAN_PERIOD + EQ_DEPTH + 4;
  logic [31:0] idle_cnt;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge core_clk_in)
  begin
    idle_cnt <= (rst_in || cfg_wr_in || pass_done_out) ? 32'h0 : idle_cnt + 32'h1;
  end
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence quiet2;
    !pass_done_out [*2];
  endsequence
  sequence cleared;
    stored_result_bit_out == '0 && !pass_done_out && !syntax_error_out && !stack_error_out;
  endsequence
  scan_rate_a: assert property (idle_cnt <= 32'(LIMIT))
    else $error("evaluation pass overdue");
  done_gap_a: assert property (pass_done_out |=> !pass_done_out)
    else $error("done pulse longer than one cycle");
  cfg_abort_a: assert property (cfg_wr_in |=> quiet2)
    else $error("done pulse right after a settings write");
  cfg_keep_a: assert property (cfg_wr_in |-> ##2 $stable(stored_result_bit_out))
    else $error("result bits moved before the new pass");
  syn_hold_a: assert property ($changed(syntax_error_out) |-> pass_done_out)
    else $error("syntax flag changed outside pass end");
  stk_hold_a: assert property ($changed(stack_error_out) |-> pass_done_out)
    else $error("stack flag changed outside pass end");
  reset_clear_a: assert property ($fell(rst_in) |-> cleared)
    else $error("outputs not cleared by reset");
  end_quiet_a: assert property (pass_done_out |-> $stable(stored_result_bit_out))
    else $error("end entry changed a result bit");
endmodule
`default_nettype wire

// ==== dv/eval_source_model.sv ====
// settings store model: writes one of four entry lists, one entry per clock
// drives after the falling edge; load_in is sampled there too
`timescale 1ns/1ps
`default_nettype none
module eval_source_model #(
  parameter int AW = 9
) (
  // clock
  input wire logic core_clk_in,
  // control from the bench
  input wire logic load_in,
  input wire logic [1:0] prog_sel_in,
  output logic busy_out,
  // settings write port
  output logic cfg_wr_out,
  output logic [AW-1:0] cfg_addr_out,
  output logic [logic_eval_pkg::ENTRY_W-1:0] cfg_data_out
);
  import logic_eval_pkg::*;
  typedef logic [ENTRY_W-1:0] ent_t;
  ent_t progs [4][$];
  int idx = 0;
  int len = 0;
  int sel = 0;
  function automatic ent_t e(logic [4:0] o, int a);
    return {o, a[7:0]};
  endfunction
  initial
  begin
    cfg_wr_out = 1'b0;
    cfg_addr_out = '0;
    cfg_data_out = '0;
    // each bit assigned once, gates within 16 inputs
    // bit 3 feeds several operators, so it is stored and read back
    progs[0] = '{e(OP_OPERATED, 2), e(OP_CONTACT, 0), e(OP_NOT, 0), e(OP_AND, 2), e(OP_ASSIGN, 3),
      e(OP_STORED, 4), e(OP_REMOTE, 0), e(OP_OR, 2), e(OP_REMOTE, 1), e(OP_PICKUP, 1), e(OP_XOR, 2),
      e(OP_STORED, 3), e(OP_OPERATED, 0), e(OP_OR, 3), e(OP_LATCH, 0), e(OP_ASSIGN, 4),
      e(OP_STORED, 3), e(OP_TIMER, 0), e(OP_ASSIGN, 5), e(OP_END, 0), e(OP_ON, 0), e(OP_ASSIGN, 6)};
    progs[1] = '{e(OP_OFF, 0), e(OP_OFF, 0), e(OP_LATCH, 0), e(OP_ASSIGN, 7), e(OP_END, 0)};
    // deliberate double assignment, only for the syntax scenario
    progs[2] = '{e(OP_ON, 0), e(OP_ASSIGN, 8), e(OP_ON, 0), e(OP_ASSIGN, 8), e(OP_END, 0)};
    // gate that asks for more operands than are stacked, then a cleared timer into a nor
    progs[3] = '{e(OP_ON, 0), e(OP_NAND, 2), e(OP_ASSIGN, 9), e(OP_TIMER_OUT, 0), e(OP_OFF, 0), e(OP_NOR, 2),
      e(OP_ASSIGN, 10), e(OP_END, 0)};
  end
  assign busy_out = cfg_wr_out || idx < len;
  always @(negedge core_clk_in)
  begin
    if (idx < len)
    begin
      cfg_wr_out <= 1'b1;
      cfg_addr_out <= idx[AW-1:0];
      cfg_data_out <= progs[sel][idx];
      idx++;
    end
    else
    begin
      // a released port toggles address and data, so the last entry recurs every other clock
      cfg_wr_out <= 1'b0;
      cfg_addr_out <= ~cfg_addr_out;
      cfg_data_out <= ~cfg_data_out;
    end
    if (load_in)
    begin
      idx = 0;
      len = progs[prog_sel_in].size();
      sel = prog_sel_in;
    end
  end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the logic evaluator
// the source model loads entry lists; the bench drives operand flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import logic_eval_pkg::*;
  localparam int SP = 600;
  localparam int AW = $clog2(EQ_DEPTH_DEF);
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic load = 1'b0;
  logic [1:0] sel = 2'h0;
  logic busy, cfg_wr, done, syn_err, stk_err;
  logic [AW-1:0] cfg_addr;
  logic [ENTRY_W-1:0] cfg_data;
  logic [NUM_CONTACTS-1:0] contact = '0;
  logic [NUM_CONTACTS-1:0] when_open = '0;
  logic [NUM_ELEMENTS-1:0] pickup = '0;
  logic [NUM_ELEMENTS-1:0] operated = '0;
  logic [NUM_REMOTE-1:0] remote = '0;
  logic [NUM_TIMERS*DELAY_W-1:0] pu_delay = '0;
  logic [NUM_TIMERS*DELAY_W-1:0] do_delay = '0;
  logic [NUM_STORED-1:0] stored;
  int n_fail = 0;
  int n_compared = 0;
  int last_wait = 0;
  // operands {op2, c0, r0, r1, p1, op0}, then bits {5, 4, 3}
  logic [8:0] rows [8] = '{9'h000, 9'h042, 9'h002, 9'h020, 9'h072, 9'h048, 9'h145, 9'h180};
  initial forever #2.5 core_clk_in = ~core_clk_in;
  logic_eval #(.SCAN_PERIOD(SP)) i_dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr), .cfg_addr_in(cfg_addr),
    .cfg_data_in(cfg_data), .contact_true_when_open_in(when_open), .timer_pickup_delay_in(pu_delay),
    .timer_dropout_delay_in(do_delay), .field_contact_input_in(contact), .pickup_flag_in(pickup),
    .operated_flag_in(operated), .remote_command_bit_in(remote), .stored_result_bit_out(stored),
    .pass_done_out(done), .syntax_error_out(syn_err), .stack_error_out(stk_err));
  eval_source_model #(.AW(AW)) i_src (
    .core_clk_in(core_clk_in), .load_in(load), .prog_sel_in(sel), .busy_out(busy),
    .cfg_wr_out(cfg_wr), .cfg_addr_out(cfg_addr), .cfg_data_out(cfg_data));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_done(input int n);
    repeat (n)
    begin
      last_wait = 0;
      do
      begin
        @(posedge core_clk_in);
        #1;
        last_wait++;
      end
      while (done !== 1'b1 && last_wait < 2 * SP);
      chk(64'(done), 64'h1);
    end
  endtask
  task automatic load_prog(input logic [1:0] p);
    int k;
    @(negedge core_clk_in);
    sel <= p;
    load <= 1'b1;
    @(negedge core_clk_in);
    load <= 1'b0;
    for (k = 0; k < 64 && (k < 2 || busy === 1'b1); k++)
      @(posedge core_clk_in);
  endtask
  task automatic drive(input logic [5:0] v);
    @(negedge core_clk_in);
    operated <= {13'h0, v[5], 1'b0, v[0]};
    contact <= {31'h0, v[4]};
    remote <= {30'h0, v[2], v[3]};
    pickup <= {14'h0, v[1], 1'b0};
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in <= 1'b0;
    chk(stored, 64'h0);
    load_prog(2'h0);
    foreach (rows[i])
    begin
      // three passes: one may be mixed, one loads the timer, one settles
      drive(rows[i][8:3]);
      wait_done(3);
      chk(stored, 64'(rows[i][2:0]) << 3);
    end
    drive(6'h20);
    when_open <= 32'h1;
    wait_done(3);
    chk(64'(stored[3]), 64'h0);
    // timer 0 delays exceed one scan period, so its output shows up only on the third pass
    drive(6'h30);
    pu_delay[15:0] <= 16'h0384;
    wait_done(2);
    chk(64'(stored[5]), 64'h0);
    wait_done(1);
    chk(64'(stored[3]), 64'h1);
    chk(64'(stored[5]), 64'h1);
    drive(6'h08);
    do_delay[15:0] <= 16'h0384;
    wait_done(2);
    chk(64'(stored[5]), 64'h1);
    wait_done(1);
    chk(64'(stored[5]), 64'h0);
    load_prog(2'h1);
    wait_done(2);
    chk(stored, 64'h10);
    load_prog(2'h2);
    wait_done(2);
    chk(64'({syn_err, stored[8]}), 64'h3);
    load_prog(2'h3);
    wait_done(2);
    chk(64'({syn_err, stk_err, stored[9], stored[10]}), 64'h5);
    // two more passes so that both ends of the measured gap come from scan ticks
    wait_done(2);
    chk(64'(last_wait), 64'(SP));
    @(negedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge core_clk_in);
    rst_in <= 1'b0;
    chk(stored, 64'h0);
    chk(64'({syn_err, stk_err}), 64'h0);
    wrap_up();
  end
  initial
  begin
    // about 41 passes are needed; this leaves ample margin
    repeat (80 * SP) @(posedge core_clk_in);
    n_fail++;
    wrap_up();
  end
endmodule
bind logic_eval logic_eval_chk #(.EQ_DEPTH(EQ_DEPTH), .SCAN_PERIOD(SCAN_PERIOD)) i_chk (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_wr_in(cfg_wr_in),
  .stored_result_bit_out(stored_result_bit_out), .pass_done_out(pass_done_out),
  .syntax_error_out(syntax_error_out), .stack_error_out(stack_error_out));
`default_nettype wire
